// file: rtl/sar_seq_pkg.sv
// Shared constants and types for the converter sequencer control block.
package sar_seq_pkg;
   // ==========================================================================
   // Channels and timing
   localparam int RES_BITS = 12;
   localparam int NUM_PINS = 8;
   localparam int NUM_CHAN = 17;
   localparam int TEMP_CHAN = 16;
   localparam longint CLK_HZ = 100_000_000;
   localparam longint CONV_CLK_MAX_HZ = 18_000_000;
   localparam int CONV_DIV = int'((CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ);
   localparam int MIN_CONV_CLKS = 18;
   localparam int SAMPLE_MIN = MIN_CONV_CLKS - RES_BITS;
   // ==========================================================================
   // Register offsets
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] CHEN_OFS = 12'h004;
   localparam logic [11:0] FWCH_OFS = 12'h008;
   localparam logic [11:0] RANGE_OFS = 12'h00C;
   localparam logic [11:0] STAT_OFS = 12'h010;
   localparam logic [11:0] INTR_OFS = 12'h014;
   localparam logic [11:0] INTCLR_OFS = 12'h018;
   localparam logic [11:0] INTEN_OFS = 12'h01C;
   localparam logic [11:0] SWFW_OFS = 12'h020;
   localparam logic [4:0] SAMPLE_PAGE = 5'h02;
   localparam logic [4:0] RESULT_PAGE = 5'h04;
   // ==========================================================================
   // Field positions and reset values
   localparam int CTRL_CONT_BIT = 0;
   localparam int CTRL_FW_BIT = 1;
   localparam int CTRL_EXP_BIT = 2;
   localparam int CTRL_TEMP_BIT = 3;
   localparam int CTRL_REF_LSB = 4;
   localparam int CTRL_SWOWN_BIT = 6;
   localparam int CTRL_START_BIT = 8;
   localparam int RANGE_HI_LSB = 16;
   localparam int INT_SCAN_BIT = 0;
   localparam int INT_RANGE_BIT = 1;
   localparam logic [6:0] CTRL_RESET = 7'h00;
   localparam logic [16:0] CHEN_RESET = 17'h000FF;
   localparam logic [7:0] SAMPLE_RESET = 8'h06;
   localparam logic [11:0] RANGE_LO_RESET = 12'h000;
   localparam logic [11:0] RANGE_HI_RESET = 12'hFFF;
   // ==========================================================================
   // Types
   typedef enum logic [1:0] {
      REF_VDD = 2'b00,
      REF_VDD_HALF = 2'b01,
      REF_BANDGAP = 2'b10,
      REF_EXT = 2'b11
   } refSrc_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONVERT = 2'b10
   } state_t;
   typedef struct packed {
      logic [4:0] chan;
      refSrc_t refSrc;
      logic sample;
      logic [11:0] dac;
      logic tempEn;
      logic [1:0] ampSw;
   } anaCtrl_t;
endpackage : sar_seq_pkg

// file: rtl/sar_adc_sequencer.sv
// Sequencer, successive-approximation logic and register file of the converter.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer (
   // Clock, reset and clock enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog side
   input wire logic compIn,
   input wire logic lowPower,
   output sar_seq_pkg::anaCtrl_t ana,
   // Interrupt
   output logic irq
);
   // ==========================================================================
   // Declarations
   sar_seq_pkg::state_t state_q;
   sar_seq_pkg::anaCtrl_t ana_q;
   logic [6:0] ctrl_q;
   logic [16:0] chEn_q;
   logic [4:0] fwChan_q;
   logic [11:0] rangeLo_q, rangeHi_q;
   logic [1:0] intr_q, intEn_q, swFw_q;
   logic startReq_q, irq_q, scanDone_q, resWrEn_q;
   logic [11:0] resData_q;
   logic [4:0] resChan_q;
   logic [3:0] bitIdx_q;
   logic [7:0] sampleCnt_q;
   logic [2:0] divCnt_q;
   logic [7:0] sampleTime_q [sar_seq_pkg::NUM_CHAN];
   logic [11:0] result_q [sar_seq_pkg::NUM_CHAN];
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   logic convTick, wrEn, rdPhase, regHit, outRange;
   logic [16:0] enEff;
   logic [5:0] nextUp, firstCh;
   logic [11:0] dacKeep;
   logic [31:0] rdData;
   logic [4:0] idx;

   function automatic logic [5:0] pickNext(input logic [16:0] en, input logic [4:0] cur,
                                           input logic wrap);
      logic [5:0] r;
      r = 6'h00;
      for (int i = sar_seq_pkg::NUM_CHAN - 1; i >= 0; i--) begin
         if (en[i] && (wrap || 5'(i) > cur)) begin
            r = {1'b1, 5'(i)};
         end
      end
      return r;
   endfunction : pickNext

   function automatic logic [7:0] effSample(input logic [7:0] t);
      return (t < 8'(sar_seq_pkg::SAMPLE_MIN)) ? 8'(sar_seq_pkg::SAMPLE_MIN) : t;
   endfunction : effSample

   // ==========================================================================
   // Converter clock and channel choice
   // The converter runs on a tick of clk, divided so it never passes 18 MHz.
   assign convTick = (divCnt_q == 3'(sar_seq_pkg::CONV_DIV - 1));
   // Pins 8..15 need the expand option; the temperature channel needs its bias on.
   assign enEff = chEn_q & {ctrl_q[sar_seq_pkg::CTRL_TEMP_BIT],
                            {8{ctrl_q[sar_seq_pkg::CTRL_EXP_BIT]}}, 8'hFF};
   assign nextUp = pickNext(enEff, ana_q.chan, 1'b0);
   assign firstCh = pickNext(enEff, 5'h00, 1'b1);
   always_comb begin
      dacKeep = ana_q.dac;
      if (!compIn) begin
         dacKeep[bitIdx_q] = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || lowPower) begin
         divCnt_q <= 3'h0;
      end else if (ce) begin
         divCnt_q <= convTick ? 3'h0 : divCnt_q + 3'h1;
      end
   end

   // ==========================================================================
   // Sequencer and successive approximation
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= sar_seq_pkg::ST_IDLE;
         ana_q <= '0;
         bitIdx_q <= 4'h0;
         sampleCnt_q <= 8'h00;
         scanDone_q <= 1'b0;
         resWrEn_q <= 1'b0;
         resData_q <= 12'h000;
         resChan_q <= 5'h00;
      end else if (ce) begin
         scanDone_q <= 1'b0;
         resWrEn_q <= 1'b0;
         ana_q.refSrc <= sar_seq_pkg::refSrc_t'(ctrl_q[sar_seq_pkg::CTRL_REF_LSB +: 2]);
         ana_q.tempEn <= ctrl_q[sar_seq_pkg::CTRL_TEMP_BIT];
         // Owning the switches, the sequencer closes them while the input is sampled.
         ana_q.ampSw <= ctrl_q[sar_seq_pkg::CTRL_SWOWN_BIT] ?
                        {2{state_q == sar_seq_pkg::ST_SAMPLE}} : swFw_q;
         if (lowPower) begin
            state_q <= sar_seq_pkg::ST_IDLE;
            ana_q.sample <= 1'b0;
         end else begin
            case (state_q)
               sar_seq_pkg::ST_IDLE: begin
                  if (startReq_q && ctrl_q[sar_seq_pkg::CTRL_FW_BIT]) begin
                     if (enEff[fwChan_q] || (fwChan_q == 5'(sar_seq_pkg::TEMP_CHAN)
                         && ctrl_q[sar_seq_pkg::CTRL_TEMP_BIT])) begin
                        ana_q.chan <= fwChan_q;
                        ana_q.sample <= 1'b1;
                        sampleCnt_q <= effSample(sampleTime_q[fwChan_q]);
                        state_q <= sar_seq_pkg::ST_SAMPLE;
                     end
                  end else if (startReq_q && firstCh[5]) begin
                     ana_q.chan <= firstCh[4:0];
                     ana_q.sample <= 1'b1;
                     sampleCnt_q <= effSample(sampleTime_q[firstCh[4:0]]);
                     state_q <= sar_seq_pkg::ST_SAMPLE;
                  end
               end
               sar_seq_pkg::ST_SAMPLE: begin
                  if (convTick) begin
                     if (sampleCnt_q <= 8'h01) begin
                        ana_q.sample <= 1'b0;
                        ana_q.dac <= 12'h800;
                        bitIdx_q <= 4'(sar_seq_pkg::RES_BITS - 1);
                        state_q <= sar_seq_pkg::ST_CONVERT;
                     end else begin
                        sampleCnt_q <= sampleCnt_q - 8'h01;
                     end
                  end
               end
               sar_seq_pkg::ST_CONVERT: begin
                  if (convTick) begin
                     if (bitIdx_q != 4'h0) begin
                        ana_q.dac <= dacKeep | (12'h001 << (bitIdx_q - 4'h1));
                        bitIdx_q <= bitIdx_q - 4'h1;
                     end else begin
                        ana_q.dac <= dacKeep;
                        resWrEn_q <= 1'b1;
                        resData_q <= dacKeep;
                        resChan_q <= ana_q.chan;
                        if (ctrl_q[sar_seq_pkg::CTRL_FW_BIT]) begin
                           scanDone_q <= 1'b1;
                           state_q <= sar_seq_pkg::ST_IDLE;
                        end else if (nextUp[5]) begin
                           // Next channel samples at once, so scans lose no converter time.
                           ana_q.chan <= nextUp[4:0];
                           ana_q.sample <= 1'b1;
                           sampleCnt_q <= effSample(sampleTime_q[nextUp[4:0]]);
                           state_q <= sar_seq_pkg::ST_SAMPLE;
                        end else begin
                           scanDone_q <= 1'b1;
                           if (ctrl_q[sar_seq_pkg::CTRL_CONT_BIT] && firstCh[5]) begin
                              ana_q.chan <= firstCh[4:0];
                              ana_q.sample <= 1'b1;
                              sampleCnt_q <= effSample(sampleTime_q[firstCh[4:0]]);
                              state_q <= sar_seq_pkg::ST_SAMPLE;
                           end else begin
                              state_q <= sar_seq_pkg::ST_IDLE;
                           end
                        end
                     end
                  end
               end
               default: state_q <= sar_seq_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // ==========================================================================
   // Per-channel buffers
   assign idx = paddr[6:2];
   for (genvar g = 0; g < sar_seq_pkg::NUM_CHAN; g++) begin : g_chan
      always_ff @(posedge clk) begin
         if (rst) begin
            sampleTime_q[g] <= sar_seq_pkg::SAMPLE_RESET;
            result_q[g] <= 12'h000;
         end else if (ce) begin
            if (wrEn && paddr[11:7] == sar_seq_pkg::SAMPLE_PAGE && idx == 5'(g)) begin
               sampleTime_q[g] <= pwdata[7:0];
            end
            if (resWrEn_q && resChan_q == 5'(g)) begin
               result_q[g] <= resData_q;
            end
         end
      end
   end

   // ==========================================================================
   // Interrupt status
   assign outRange = (resData_q < rangeLo_q) || (resData_q > rangeHi_q);
   always_ff @(posedge clk) begin
      if (rst) begin
         intr_q <= 2'b00;
         irq_q <= 1'b0;
      end else if (ce) begin
         // A hardware event in the same cycle as a software clear stays set.
         intr_q[sar_seq_pkg::INT_SCAN_BIT] <= scanDone_q ||
            (intr_q[sar_seq_pkg::INT_SCAN_BIT] && !(wrEn && paddr == sar_seq_pkg::INTCLR_OFS
            && pwdata[sar_seq_pkg::INT_SCAN_BIT]));
         intr_q[sar_seq_pkg::INT_RANGE_BIT] <= (resWrEn_q && outRange) ||
            (intr_q[sar_seq_pkg::INT_RANGE_BIT] && !(wrEn && paddr == sar_seq_pkg::INTCLR_OFS
            && pwdata[sar_seq_pkg::INT_RANGE_BIT]));
         irq_q <= |(intr_q & intEn_q);
      end
   end

   // ==========================================================================
   // APB register file
   // Every access waits one cycle so the read data comes from a flip-flop.
   assign rdPhase = psel && penable && !pready_q;
   assign wrEn = psel && penable && pready_q && pwrite;
   always_comb begin
      rdData = 32'h0000_0000;
      regHit = 1'b1;
      if (paddr[11:7] == sar_seq_pkg::SAMPLE_PAGE && idx < 5'(sar_seq_pkg::NUM_CHAN)) begin
         rdData = {24'h00_0000, sampleTime_q[idx]};
      end else if (paddr[11:7] == sar_seq_pkg::RESULT_PAGE
                   && idx < 5'(sar_seq_pkg::NUM_CHAN)) begin
         rdData = {20'h0_0000, result_q[idx]};
      end else begin
         case (paddr)
            sar_seq_pkg::CTRL_OFS: rdData = {25'h000_0000, ctrl_q};
            sar_seq_pkg::CHEN_OFS: rdData = {15'h0000, chEn_q};
            sar_seq_pkg::FWCH_OFS: rdData = {27'h000_0000, fwChan_q};
            sar_seq_pkg::RANGE_OFS: rdData = {4'h0, rangeHi_q, 4'h0, rangeLo_q};
            sar_seq_pkg::STAT_OFS: rdData = {24'h00_0000, ana_q.chan, 1'b0, state_q};
            sar_seq_pkg::INTR_OFS: rdData = {30'h0000_0000, intr_q};
            sar_seq_pkg::INTCLR_OFS: rdData = 32'h0000_0000;
            sar_seq_pkg::INTEN_OFS: rdData = {30'h0000_0000, intEn_q};
            sar_seq_pkg::SWFW_OFS: rdData = {30'h0000_0000, swFw_q};
            default: regHit = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (ce) begin
         pready_q <= rdPhase;
         if (rdPhase) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rdData;
            pslverr_q <= !regHit;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= sar_seq_pkg::CTRL_RESET;
         chEn_q <= sar_seq_pkg::CHEN_RESET;
         fwChan_q <= 5'h00;
         rangeLo_q <= sar_seq_pkg::RANGE_LO_RESET;
         rangeHi_q <= sar_seq_pkg::RANGE_HI_RESET;
         intEn_q <= 2'b00;
         swFw_q <= 2'b00;
         startReq_q <= 1'b0;
      end else if (ce) begin
         startReq_q <= 1'b0;
         if (wrEn) begin
            case (paddr)
               sar_seq_pkg::CTRL_OFS: begin
                  ctrl_q <= pwdata[6:0];
                  startReq_q <= pwdata[sar_seq_pkg::CTRL_START_BIT];
               end
               sar_seq_pkg::CHEN_OFS: chEn_q <= pwdata[16:0];
               sar_seq_pkg::FWCH_OFS: fwChan_q <= pwdata[4:0];
               sar_seq_pkg::RANGE_OFS: begin
                  rangeLo_q <= pwdata[11:0];
                  rangeHi_q <= pwdata[sar_seq_pkg::RANGE_HI_LSB +: 12];
               end
               sar_seq_pkg::INTEN_OFS: intEn_q <= pwdata[1:0];
               sar_seq_pkg::SWFW_OFS: swFw_q <= pwdata[1:0];
               default: ;
            endcase
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign ana = ana_q;
   assign irq = irq_q;

   // ==========================================================================
   // Checks
   logic [8:0] sampT_q;
   logic [4:0] bitT_q;
   // The trial counters freeze with the clock enable, like the state they measure.
   always_ff @(posedge clk) begin
      if (rst) begin
         sampT_q <= 9'h000;
         bitT_q <= 5'h00;
      end else if (ce) begin
         if (resWrEn_q || state_q == sar_seq_pkg::ST_IDLE) begin
            sampT_q <= 9'h000;
            bitT_q <= 5'h00;
         end else if (convTick && state_q == sar_seq_pkg::ST_SAMPLE) begin
            sampT_q <= sampT_q + 9'h001;
         end else if (convTick && state_q == sar_seq_pkg::ST_CONVERT) begin
            bitT_q <= bitT_q + 5'h01;
         end
      end
   end

   bit_trials_a: assert property (@(posedge clk) disable iff (rst)
      resWrEn_q |-> bitT_q == 5'(sar_seq_pkg::RES_BITS))
      else $error("conversion did not take twelve bit trials");
   conv_length_a: assert property (@(posedge clk) disable iff (rst)
      resWrEn_q |-> (sampT_q + 9'(bitT_q)) >= 9'(sar_seq_pkg::MIN_CONV_CLKS))
      else $error("conversion shorter than eighteen converter clocks");
   sample_time_a: assert property (@(posedge clk) disable iff (rst)
      resWrEn_q |-> sampT_q == {1'b0, effSample(sampleTime_q[resChan_q])})
      else $error("sample time differs from the channel setting");
   chan_range_a: assert property (@(posedge clk) disable iff (rst)
      (state_q != sar_seq_pkg::ST_IDLE && !ctrl_q[sar_seq_pkg::CTRL_EXP_BIT])
      |-> (ana_q.chan < 5'(sar_seq_pkg::NUM_PINS) || ana_q.chan == 5'(sar_seq_pkg::TEMP_CHAN)))
      else $error("expanded channel converted while expansion is off");
   no_gap_a: assert property (@(posedge clk) disable iff (rst)
      (ce && !lowPower && convTick && state_q == sar_seq_pkg::ST_CONVERT && bitIdx_q == 4'h0
       && !ctrl_q[sar_seq_pkg::CTRL_FW_BIT] && nextUp[5])
      |=> state_q == sar_seq_pkg::ST_SAMPLE && {1'b1, ana_q.chan} == $past(nextUp))
      else $error("scan idled between channels");
   range_flag_a: assert property (@(posedge clk) disable iff (rst)
      (ce && resWrEn_q && outRange) |=> intr_q[sar_seq_pkg::INT_RANGE_BIT])
      else $error("out-of-range result raised no flag");
   scan_flag_a: assert property (@(posedge clk) disable iff (rst)
      (ce && scanDone_q) |=> intr_q[sar_seq_pkg::INT_SCAN_BIT])
      else $error("scan end raised no flag");
   flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
      (intr_q[sar_seq_pkg::INT_SCAN_BIT] && !(wrEn && paddr == sar_seq_pkg::INTCLR_OFS))
      |=> intr_q[sar_seq_pkg::INT_SCAN_BIT])
      else $error("scan flag dropped without a clear");
   irq_gate_a: assert property (@(posedge clk) disable iff (rst)
      ce |=> irq_q == (|($past(intr_q) & $past(intEn_q))))
      else $error("interrupt output does not follow enabled flags");
   deep_sleep_a: assert property (@(posedge clk) disable iff (rst)
      (ce && lowPower) |=> state_q == sar_seq_pkg::ST_IDLE && !ana_q.sample)
      else $error("converter active in a low-power mode");
endmodule : sar_adc_sequencer
`default_nettype wire

// file: tb/analog_front_model.sv
// Behavioural comparator and pin levels that sit on the analog side of the sequencer.
`timescale 1ns/10ps
`default_nettype none
module analog_front_model (
   // Clock
   input wire logic clk,
   // Converter side
   input wire sar_seq_pkg::anaCtrl_t ana,
   output logic compIn
);
   // ==========================================================================
   // Pin levels and comparator
   // Channels 0..15 carry distinct fixed levels and the temperature channel repeats channel 0's,
   // so among pins a result stored in the wrong buffer shows up as a wrong value.
   logic [11:0] level;
   always_comb level = 12'h0A5 + {ana.chan[3:0], 8'h00};
   always @(posedge clk) begin
      compIn <= (level >= ana.dac);
   end
endmodule : analog_front_model
`default_nettype wire

// file: tb/test_sar_adc_sequencer.sv
// Self-checking bench for the converter sequencer control block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin testsRun++; if ((a) !== (e)) begin numErrors++; $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module test_sar_adc_sequencer;
   // ==========================================================================
   // Stimulus, design and analog side
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic compIn;
   logic lowPower = 1'b0;
   logic ce = 1'b1;
   sar_seq_pkg::anaCtrl_t snap;
   logic irq;
   sar_seq_pkg::anaCtrl_t ana;
   int numErrors = 0;
   int testsRun = 0;
   int cycles = 0;
   int curLen = 0;
   int lowLen = 0;
   int sampLen [17] = '{default: 0};
   int gapLen [17] = '{default: 0};
   logic [31:0] rdat;
   logic rerr;
   initial forever #5 clk = ~clk;
   sar_adc_sequencer sar_adc_sequencer_i (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .compIn(compIn), .lowPower(lowPower), .ana(ana),
      .irq(irq));
   analog_front_model analog_front_model_i (.clk(clk), .ana(ana), .compIn(compIn));
   // ==========================================================================
   // Monitor and hang guard
   // Sample windows and the idle gap before each are measured per channel.
   always @(posedge clk) begin
      cycles++;
      if (ana.sample) begin
         if (curLen == 0) gapLen[ana.chan] = lowLen;
         curLen++;
         lowLen = 0;
      end else begin
         if (curLen != 0) sampLen[ana.chan] = curLen;
         curLen = 0;
         lowLen++;
      end
      if (cycles == 30000) begin
         numErrors++;
         completeRun();
      end
   end
   // ==========================================================================
   // Bus tasks
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the cycle ceiling of the monitor ends a wait that never completes.
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      `CHK(rdat, e)
   endtask : rdChk
   task automatic waitDone();
      do begin
         xfer(1'b0, sar_seq_pkg::INTR_OFS, 32'h0000_0000);
      end while (rdat[0] !== 1'b1);
   endtask : waitDone
   function automatic logic [31:0] lvl(input logic [3:0] c);
      return {20'h00000, 12'h0A5 + {c, 8'h00}};
   endfunction : lvl
   task automatic completeRun();
      $display("comparisons %0d mismatches %0d", testsRun, numErrors);
      if (numErrors == 0 && testsRun > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : completeRun
   // ==========================================================================
   // Tests
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rdChk(sar_seq_pkg::CHEN_OFS, 32'h0000_00FF);
      rdChk(sar_seq_pkg::RANGE_OFS, 32'h0FFF_0000);
      rdChk(12'h100, 32'h0000_0006);
      xfer(1'b1, sar_seq_pkg::INTR_OFS, 32'h0000_0003);
      rdChk(sar_seq_pkg::INTR_OFS, 32'h0000_0000);
      xfer(1'b0, 12'h300, 32'h0000_0000);
      `CHK(rerr, 1'b1)
      `CHK(irq, 1'b0)
      $display("reset values test done");
      xfer(1'b1, sar_seq_pkg::CHEN_OFS, 32'h0000_0003);
      xfer(1'b1, 12'h104, 32'h0000_000A);
      xfer(1'b1, sar_seq_pkg::RANGE_OFS, 32'h0600_0100);
      xfer(1'b1, sar_seq_pkg::INTEN_OFS, 32'h0000_0003);
      xfer(1'b1, sar_seq_pkg::CTRL_OFS, 32'h0000_0100);
      waitDone();
      rdChk(12'h200, lvl(4'h0));
      rdChk(12'h204, lvl(4'h1));
      rdChk(sar_seq_pkg::INTR_OFS, 32'h0000_0003);
      `CHK(irq, 1'b1)
      // Channel 1 starts on a converter tick, so its window is a whole number of ticks.
      `CHK(sampLen[1], 10 * sar_seq_pkg::CONV_DIV)
      `CHK(gapLen[1], sar_seq_pkg::RES_BITS * sar_seq_pkg::CONV_DIV)
      xfer(1'b1, sar_seq_pkg::INTCLR_OFS, 32'h0000_0001);
      rdChk(sar_seq_pkg::INTR_OFS, 32'h0000_0002);
      `CHK(irq, 1'b1)
      xfer(1'b1, sar_seq_pkg::INTEN_OFS, 32'h0000_0000);
      rdChk(sar_seq_pkg::INTR_OFS, 32'h0000_0002);
      `CHK(irq, 1'b0)
      xfer(1'b1, sar_seq_pkg::INTCLR_OFS, 32'h0000_0002);
      rdChk(sar_seq_pkg::INTR_OFS, 32'h0000_0000);
      $display("scan and range test done");
      xfer(1'b1, sar_seq_pkg::CHEN_OFS, 32'h0000_00FF);
      xfer(1'b1, sar_seq_pkg::FWCH_OFS, 32'h0000_0005);
      xfer(1'b1, sar_seq_pkg::CTRL_OFS, 32'h0000_0102);
      waitDone();
      rdChk(12'h214, lvl(4'h5));
      rdChk(sar_seq_pkg::INTR_OFS, 32'h0000_0001);
      xfer(1'b1, sar_seq_pkg::INTCLR_OFS, 32'h0000_0003);
      $display("firmware select test done");
      for (int r = 0; r < 4; r++) begin
         xfer(1'b1, sar_seq_pkg::SWFW_OFS, 32'(r));
         xfer(1'b1, sar_seq_pkg::CTRL_OFS, 32'(r) << 4);
         repeat (2) @(posedge clk);
         `CHK(ana.refSrc, 2'(r))
         `CHK(ana.ampSw, 2'(r))
      end
      $display("reference and switch test done");
      xfer(1'b1, sar_seq_pkg::CHEN_OFS, 32'h0001_0000);
      xfer(1'b1, sar_seq_pkg::CTRL_OFS, 32'h0000_0149);
      waitDone();
      rdChk(12'h240, lvl(4'h0));
      xfer(1'b1, sar_seq_pkg::INTCLR_OFS, 32'h0000_0001);
      waitDone();
      xfer(1'b0, sar_seq_pkg::STAT_OFS, 32'h0000_0000);
      `CHK(rdat[1:0] != 2'b00, 1'b1)
      `CHK(ana.tempEn, 1'b1)
      // With the clock enable low the running scan must not move at all.
      ce <= 1'b0;
      @(posedge clk);
      snap = ana;
      repeat (20) @(posedge clk);
      `CHK(ana, snap)
      ce <= 1'b1;
      lowPower <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK(ana.sample, 1'b0)
      `CHK(ana.ampSw, 2'b00)
      xfer(1'b0, sar_seq_pkg::STAT_OFS, 32'h0000_0000);
      `CHK(rdat[1:0], 2'b00)
      lowPower <= 1'b0;
      $display("temperature and low power test done");
      completeRun();
   end
endmodule : test_sar_adc_sequencer
`default_nettype wire
